/* File: rtl/link_status_pkg.sv */
// Constants, field positions and reset values of the link status register bank.
// Assumes an APB master with 32-bit data; registers hold 8 bits in the low byte.
//
// Operation
// - Alias bits 7:1 hold decoder compare address
// - Matching transaction forwarded with remote address
// - Zero alias disables its entry
// - Bit 0 auto-acknowledges writes to target
// - Bit 5 write-one clears self-test counter
// - Bit 3 write-one clears checksum error counter
// - Bits 2:0 hold link-detect timer value
// - Status bit 7 shows valid fuse checksum
// - Status bit 6 shows initialization complete
// - General bit 6 shows remote lock
// - General bit 4 flags link-lost change
// - General bit 3 flags self-test error
// - General bit 2 shows forward PLL lock
// - General bit 1 flags checksum error
// - General bit 0 shows link valid
// - Pin status bits 3:0 show pins
// - Eight-bit self-test checksum error count
// - Sixteen-bit checksum error count, two bytes
// - Temperature over/under flags, cleared on read
// - Pin1 voltage over/under flags, cleared on read
// - Pin0 voltage over/under flags, cleared on read
package link_status_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;

    // ------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_REMOTE_ALIAS_SIX = 10'h047;
    localparam logic [IDX_W-1:0] IDX_REMOTE_ALIAS_SEVEN = 10'h048;
    localparam logic [IDX_W-1:0] IDX_BACK_CHANNEL_CONTROL = 10'h049;
    localparam logic [IDX_W-1:0] IDX_REVISION_AND_MASK = 10'h050;
    localparam logic [IDX_W-1:0] IDX_INIT_STATUS = 10'h051;
    localparam logic [IDX_W-1:0] IDX_GENERAL_LINK_STATUS = 10'h052;
    localparam logic [IDX_W-1:0] IDX_PIN_LEVEL_SNAPSHOT = 10'h053;
    localparam logic [IDX_W-1:0] IDX_SELFTEST_ERROR_COUNT = 10'h054;
    localparam logic [IDX_W-1:0] IDX_CHECKSUM_COUNT_LOW = 10'h055;
    localparam logic [IDX_W-1:0] IDX_CHECKSUM_COUNT_HIGH = 10'h056;
    localparam logic [IDX_W-1:0] IDX_LIMIT_ALARM_FLAGS = 10'h057;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ALIAS_AUTO_ACK_BIT = 0;
    localparam int CTRL_SELFTEST_WIPE_BIT = 5;
    localparam int CTRL_CHECKSUM_WIPE_BIT = 3;
    localparam int INIT_FUSE_VALID_BIT = 7;
    localparam int INIT_DONE_BIT = 6;
    localparam int GEN_REMOTE_LOCK_BIT = 6;
    localparam int GEN_LINK_LOST_BIT = 4;
    localparam int GEN_SELFTEST_FAULT_BIT = 3;
    localparam int GEN_PLL_LOCK_BIT = 2;
    localparam int GEN_CHECKSUM_ERR_BIT = 1;
    localparam int GEN_LINK_VALID_BIT = 0;
    localparam int TIMER_W = 3;
    localparam int PIN_N = 4;
    localparam int ALARM_N = 6;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [REG_W-1:0] ALIAS_RESET = 8'h00;
    localparam logic [TIMER_W-1:0] TIMER_RESET = 3'h0;
    localparam logic PLL_LOCK_RESET = 1'b1;
    localparam logic LINK_VALID_RESET = 1'b1;

endpackage : link_status_pkg

/* File: rtl/link_status_register_bank.sv */
// Register bank of the serializer: alias decoder, back-channel control,
// link status flags, error counters and limit alarm flags, on an APB slave.
// Assumes APB inputs and status inputs are synchronous to i_clk.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
module link_status_register_bank #(
    parameter logic [3:0] SILICON_REVISION = 4'h3, // Arbitrary value
    parameter logic [3:0] MASK_CODE = 4'h1 // Arbitrary value
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [link_status_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [link_status_pkg::DATA_W-1:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [link_status_pkg::DATA_W-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_txn_valid,
    input wire logic i_txn_write,
    input wire logic [6:0] i_txn_addr,
    input wire logic [6:0] i_remote_id_six,
    input wire logic [6:0] i_remote_id_seven,
    output logic o_fwd_valid,
    output logic o_fwd_write,
    output logic [6:0] o_fwd_addr,
    output logic o_auto_ack,
    output logic [link_status_pkg::TIMER_W-1:0] o_link_detect_interval,
    input wire logic i_init_done,
    input wire logic i_fuse_config_valid,
    input wire logic i_remote_locked,
    input wire logic i_forward_pll_locked,
    input wire logic i_backchannel_link_valid,
    input wire logic i_backchannel_checksum_error,
    input wire logic i_selftest_checksum_error,
    input wire logic [link_status_pkg::PIN_N-1:0] i_pin_levels,
    input wire logic [link_status_pkg::ALARM_N-1:0] i_limit_alarm
);
    import link_status_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [REG_W-1:0] alias_six_q;
    logic [REG_W-1:0] alias_seven_q;
    logic [TIMER_W-1:0] timer_q;
    logic selftest_counter_wipe_q;
    logic checksum_fault_wipe_q;
    logic init_done_q;
    logic fuse_config_valid_q;
    logic remote_locked_q;
    logic forward_pll_locked_q;
    logic backchannel_link_valid_q;
    logic link_lost_q;
    logic selftest_fault_seen_q;
    logic checksum_err_q;
    logic [PIN_N-1:0] pin_levels_q;
    logic [REG_W-1:0] selftest_fault_count_q;
    logic [15:0] checksum_fault_count_q;
    logic [ALARM_N-1:0] alarm_q;
    logic [DATA_W-1:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic fwd_valid_q;
    logic fwd_write_q;
    logic [6:0] fwd_addr_q;
    logic auto_ack_q;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire [IDX_W-1:0] idx = i_paddr[ADDR_W-1:2];
    wire aligned = (i_paddr[1:0] == 2'h0);
    wire setup = i_psel & ~i_penable & ~pready_q;
    wire done = i_psel & i_penable & pready_q;
    wire wr_done = done & i_pwrite & ~pslverr_q & i_pstrb[0];
    wire rd_done = done & ~i_pwrite & ~pslverr_q;
    wire hit_a6 = aligned & (idx == IDX_REMOTE_ALIAS_SIX);
    wire hit_a7 = aligned & (idx == IDX_REMOTE_ALIAS_SEVEN);
    wire hit_ctl = aligned & (idx == IDX_BACK_CHANNEL_CONTROL);
    wire hit_rev = aligned & (idx == IDX_REVISION_AND_MASK);
    wire hit_ini = aligned & (idx == IDX_INIT_STATUS);
    wire hit_gen = aligned & (idx == IDX_GENERAL_LINK_STATUS);
    wire hit_pin = aligned & (idx == IDX_PIN_LEVEL_SNAPSHOT);
    wire hit_stc = aligned & (idx == IDX_SELFTEST_ERROR_COUNT);
    wire hit_cl = aligned & (idx == IDX_CHECKSUM_COUNT_LOW);
    wire hit_ch = aligned & (idx == IDX_CHECKSUM_COUNT_HIGH);
    wire hit_alm = aligned & (idx == IDX_LIMIT_ALARM_FLAGS);
    wire mapped = hit_a6 | hit_a7 | hit_ctl | hit_rev | hit_ini | hit_gen
                  | hit_pin | hit_stc | hit_cl | hit_ch | hit_alm;

    // Register views, reserved bits tied low
    wire [REG_W-1:0] v_ctl = {5'h00, timer_q};
    wire [REG_W-1:0] v_rev = {SILICON_REVISION, MASK_CODE};
    wire [REG_W-1:0] v_ini = {fuse_config_valid_q, init_done_q, 6'h00};
    wire [REG_W-1:0] v_gen = {1'b0, remote_locked_q, 1'b0, link_lost_q,
                              selftest_fault_seen_q, forward_pll_locked_q,
                              checksum_err_q, backchannel_link_valid_q};
    wire [REG_W-1:0] v_pin = {4'h0, pin_levels_q};
    wire [REG_W-1:0] v_alm = {2'h0, alarm_q};

    // Read data selection
    wire [REG_W-1:0] rd_byte =
        hit_a6 ? alias_six_q :
        hit_a7 ? alias_seven_q :
        hit_ctl ? v_ctl :
        hit_rev ? v_rev :
        hit_ini ? v_ini :
        hit_gen ? v_gen :
        hit_pin ? v_pin :
        hit_stc ? selftest_fault_count_q :
        hit_cl ? checksum_fault_count_q[7:0] :
        hit_ch ? checksum_fault_count_q[15:8] :
        hit_alm ? v_alm : 8'h00;

    // ------------------------------------------------------------
    // Event terms
    // ------------------------------------------------------------
    wire wipe_selftest = selftest_counter_wipe_q;
    wire wipe_checksum = checksum_fault_wipe_q;
    wire ctl_read = rd_done & hit_ctl;
    wire alarm_read = rd_done & hit_alm;
    wire link_change = i_backchannel_link_valid ^ backchannel_link_valid_q;
    wire pll_lost = forward_pll_locked_q & ~i_forward_pll_locked;
    wire crc_event = i_backchannel_checksum_error & i_backchannel_link_valid;
    wire [REG_W-1:0] st_inc = selftest_fault_count_q + 8'h01;
    wire [15:0] ck_inc = checksum_fault_count_q + 16'h0001;
    wire st_sat = &selftest_fault_count_q;
    wire ck_sat = &checksum_fault_count_q;

    // Alias compare; zero alias never matches
    wire [6:0] a6_addr = alias_six_q[7:1];
    wire [6:0] a7_addr = alias_seven_q[7:1];
    wire m6 = i_txn_valid & (a6_addr != 7'h00) & (i_txn_addr == a6_addr);
    wire m7 = i_txn_valid & (a7_addr != 7'h00) & (i_txn_addr == a7_addr);
    wire ack6 = m6 & i_txn_write & alias_six_q[ALIAS_AUTO_ACK_BIT];
    // Entry six wins a double match, so seven's auto-ack must yield to it too
    wire ack7 = m7 & ~m6 & i_txn_write & alias_seven_q[ALIAS_AUTO_ACK_BIT];

    // ------------------------------------------------------------
    // APB answer: registered one cycle after setup
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= setup;
            pslverr_q <= setup & ~mapped;
            if (setup)
            begin
                prdata_q <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ------------------------------------------------------------
    // Writable registers and self-clearing wipes
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            alias_six_q <= ALIAS_RESET;
            alias_seven_q <= ALIAS_RESET;
            timer_q <= TIMER_RESET;
            selftest_counter_wipe_q <= 1'b0;
            checksum_fault_wipe_q <= 1'b0;
        end
        else
        begin
            if (wr_done & hit_a6)
            begin
                alias_six_q <= i_pwdata[7:0];
            end
            if (wr_done & hit_a7)
            begin
                alias_seven_q <= i_pwdata[7:0];
            end
            if (wr_done & hit_ctl)
            begin
                timer_q <= i_pwdata[TIMER_W-1:0];
            end
            // Each wipe lives one cycle, then clears itself
            selftest_counter_wipe_q <= wr_done & hit_ctl
                                       & i_pwdata[CTRL_SELFTEST_WIPE_BIT];
            checksum_fault_wipe_q <= wr_done & hit_ctl
                                     & i_pwdata[CTRL_CHECKSUM_WIPE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Status samples; init done and fuse valid hold once set
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            init_done_q <= 1'b0;
            fuse_config_valid_q <= 1'b0;
            remote_locked_q <= 1'b0;
            forward_pll_locked_q <= PLL_LOCK_RESET;
            backchannel_link_valid_q <= LINK_VALID_RESET;
            pin_levels_q <= 4'h0;
        end
        else
        begin
            init_done_q <= init_done_q | i_init_done;
            fuse_config_valid_q <= fuse_config_valid_q
                                   | (i_init_done & i_fuse_config_valid);
            remote_locked_q <= i_remote_locked;
            forward_pll_locked_q <= i_forward_pll_locked;
            backchannel_link_valid_q <= i_backchannel_link_valid;
            pin_levels_q <= i_pin_levels;
        end
    end

    // ------------------------------------------------------------
    // Sticky flags; a new event beats a clear in the same cycle
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            link_lost_q <= 1'b0;
            selftest_fault_seen_q <= 1'b0;
            checksum_err_q <= 1'b0;
            alarm_q <= 6'h00;
        end
        else
        begin
            link_lost_q <= link_change
                           | (link_lost_q & ~(ctl_read | pll_lost));
            selftest_fault_seen_q <= i_selftest_checksum_error
                                     | (selftest_fault_seen_q & ~wipe_selftest);
            checksum_err_q <= crc_event | (checksum_err_q & ~ctl_read);
            alarm_q <= i_limit_alarm | (alarm_q & ~{ALARM_N{alarm_read}});
        end
    end

    // ------------------------------------------------------------
    // Error counters, saturating; a count in the wipe cycle is kept
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            selftest_fault_count_q <= 8'h00;
            checksum_fault_count_q <= 16'h0000;
        end
        else
        begin
            if (wipe_selftest)
            begin
                selftest_fault_count_q <= {7'h00, i_selftest_checksum_error};
            end
            else if (i_selftest_checksum_error & ~st_sat)
            begin
                selftest_fault_count_q <= st_inc;
            end
            if (wipe_checksum)
            begin
                checksum_fault_count_q <= {15'h0000, i_backchannel_checksum_error};
            end
            else if (i_backchannel_checksum_error & ~ck_sat)
            begin
                checksum_fault_count_q <= ck_inc;
            end
        end
    end

    // ------------------------------------------------------------
    // Alias decoder outputs, one cycle after the transaction
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            fwd_valid_q <= 1'b0;
            fwd_write_q <= 1'b0;
            fwd_addr_q <= 7'h00;
            auto_ack_q <= 1'b0;
        end
        else
        begin
            fwd_valid_q <= m6 | m7;
            fwd_write_q <= i_txn_write & (m6 | m7);
            fwd_addr_q <= m6 ? i_remote_id_six : (m7 ? i_remote_id_seven : 7'h00);
            auto_ack_q <= ack6 | ack7;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_fwd_valid = fwd_valid_q;
    assign o_fwd_write = fwd_write_q;
    assign o_fwd_addr = fwd_addr_q;
    assign o_auto_ack = auto_ack_q;
    assign o_link_detect_interval = timer_q;

endmodule : link_status_register_bank

/* File: verif/link_bank_monitor.sv */
// Port-level checks of the link status register bank.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module link_bank_monitor
    import link_status_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [link_status_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [link_status_pkg::DATA_W-1:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic [link_status_pkg::DATA_W-1:0] o_prdata,
    input wire logic o_pready,
    input wire logic i_txn_valid,
    input wire logic i_txn_write,
    input wire logic [6:0] i_txn_addr,
    input wire logic [6:0] i_remote_id_six,
    input wire logic [6:0] i_remote_id_seven,
    input wire logic o_fwd_valid,
    input wire logic o_fwd_write,
    input wire logic [6:0] o_fwd_addr,
    input wire logic o_auto_ack,
    input wire logic [link_status_pkg::TIMER_W-1:0] o_link_detect_interval
);
    // Timer field of the write data
    wire logic [2:0] wr_timer = i_pwdata[2:0];

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    // Bus phases
    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_ctrl_wr;
        s_setup ##1 (i_pwrite && i_pstrb[0] && o_pready
            && i_paddr == {IDX_BACK_CHANNEL_CONTROL, 2'h0});
    endsequence

    a_ready_one_cycle: assert property (s_setup |=> o_pready)
        else $error("ready missing after setup");
    a_ready_in_access: assert property (o_pready |-> i_psel && i_penable)
        else $error("ready outside access");
    a_rdata_upper_zero: assert property (o_pready && !i_pwrite |-> o_prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_timer_written: assert property (s_ctrl_wr |=> o_link_detect_interval == $past(wr_timer))
        else $error("timer field not written");
    a_fwd_has_cause: assert property (o_fwd_valid |-> $past(i_txn_valid) && $past(i_txn_addr) != 7'h00)
        else $error("forward without live transaction");
    a_fwd_remote_addr: assert property (o_fwd_valid |->
        o_fwd_addr == $past(i_remote_id_six) || o_fwd_addr == $past(i_remote_id_seven))
        else $error("forward address not a remote id");
    a_fwd_write_kept: assert property (o_fwd_valid |-> o_fwd_write == $past(i_txn_write))
        else $error("forward direction changed");
    a_auto_ack_write: assert property (o_auto_ack |-> o_fwd_valid && o_fwd_write)
        else $error("auto ack without forwarded write");
endmodule : link_bank_monitor

bind link_status_register_bank link_bank_monitor i_mon (.i_clk, .i_reset_n, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_prdata, .o_pready, .i_txn_valid, .i_txn_write,
    .i_txn_addr, .i_remote_id_six, .i_remote_id_seven, .o_fwd_valid, .o_fwd_write, .o_fwd_addr,
    .o_auto_ack, .o_link_detect_interval);

/* File: verif/remote_deser_model.sv */
// Behavioural model of the remote deserializer across the back channel.
// Assumes the bench commands link state and error bursts by levels.
`timescale 1ns/1ps
module remote_deser_model (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_link_up,
    input wire logic i_inject_crc,
    input wire logic i_inject_bist,
    output logic o_remote_locked,
    output logic o_link_valid,
    output logic o_crc_error,
    output logic o_bist_error
);
    // Lock, link and error events one stage after the commands
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_remote_locked <= 1'h1;
            o_link_valid <= 1'h1;
            o_crc_error <= 1'h0;
            o_bist_error <= 1'h0;
        end
        else
        begin
            o_remote_locked <= i_link_up;
            o_link_valid <= i_link_up;
            o_crc_error <= i_inject_crc && i_link_up; // Checksum errors only seen on a live link; self-test errors always pass
            o_bist_error <= i_inject_bist;
        end
    end
endmodule : remote_deser_model

/* File: verif/testbench.sv */
// Self-checking bench of the link status register bank with a remote model.
// Assumes APB answers within a few cycles and status follows inputs shortly.
`timescale 1ns/1ps
module testbench;
    import link_status_pkg::*;
    localparam logic [3:0] REV = 4'h5; // Arbitrary value
    localparam logic [3:0] MASK = 4'ha; // Arbitrary value
    logic i_clk = 1'h0, i_reset_n = 1'h0, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
    logic [ADDR_W-1:0] i_paddr = 12'h0;
    logic [DATA_W-1:0] i_pwdata = 32'h0, o_prdata, rd;
    logic [3:0] i_pstrb = 4'hf, i_pin_levels = 4'h0;
    logic o_pready, o_pslverr, o_fwd_valid, o_fwd_write, o_auto_ack, err;
    logic i_txn_valid = 1'h0, i_txn_write = 1'h0, i_init_done = 1'h0, i_fuse_config_valid = 1'h0;
    logic i_forward_pll_locked = 1'h1, link_up = 1'h1, inj_crc = 1'h0, inj_bist = 1'h0;
    logic i_remote_locked, i_backchannel_link_valid, i_backchannel_checksum_error;
    logic i_selftest_checksum_error;
    logic [6:0] i_txn_addr = 7'h0, i_remote_id_six = 7'h15, i_remote_id_seven = 7'h2a, o_fwd_addr;
    logic [TIMER_W-1:0] o_link_detect_interval;
    logic [ALARM_N-1:0] i_limit_alarm = 6'h0;
    logic [7:0] a6 = 8'h0, a7 = 8'h0;
    int num_errors = 0, checks = 0, seed = 12;

    always #12.5 i_clk = ~i_clk;

    link_status_register_bank #(.SILICON_REVISION(REV), .MASK_CODE(MASK)) i_dut (.i_clk,
        .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_prdata,
        .o_pready, .o_pslverr, .i_txn_valid, .i_txn_write, .i_txn_addr, .i_remote_id_six,
        .i_remote_id_seven, .o_fwd_valid, .o_fwd_write, .o_fwd_addr, .o_auto_ack,
        .o_link_detect_interval, .i_init_done, .i_fuse_config_valid, .i_remote_locked,
        .i_forward_pll_locked, .i_backchannel_link_valid, .i_backchannel_checksum_error,
        .i_selftest_checksum_error, .i_pin_levels, .i_limit_alarm);
    remote_deser_model i_far (.i_clk, .i_reset_n, .i_link_up(link_up), .i_inject_crc(inj_crc),
        .i_inject_bist(inj_bist), .o_remote_locked(i_remote_locked),
        .o_link_valid(i_backchannel_link_valid), .o_crc_error(i_backchannel_checksum_error),
        .o_bist_error(i_selftest_checksum_error));

    // Compare, report and close
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test
    // One APB transfer; read data and error taken at the completing edge
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge i_clk);
        i_psel <= 1'h1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= {24'h0, wd};
        @(posedge i_clk);
        i_penable <= 1'h1;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (o_pready !== 1'h1 && n < 20);
        rd = o_prdata;
        err = o_pslverr;
        if (o_pready !== 1'h1)
        begin
            chk("pready", 32'h0, 32'h1);
            stop_test();
        end
        i_psel <= 1'h0;
        i_penable <= 1'h0;
    endtask : apb
    task automatic rchk(input string nm, input logic [IDX_W-1:0] idx, input logic [7:0] exp);
        apb(1'h0, {idx, 2'h0}, 8'h0);
        chk(nm, rd, {24'h0, exp});
    endtask : rchk
    // Expected general status from the present levels
    function automatic logic [7:0] gen_exp(input logic lost, input logic bist, input logic crc);
        return {1'h0, i_remote_locked, 1'h0, lost, bist, i_forward_pll_locked, crc,
            i_backchannel_link_valid};
    endfunction : gen_exp
    // One control transaction through the alias decoder
    task automatic txn(input logic [6:0] t, input logic w);
        logic h6, h7;
        h6 = t != 7'h0 && t == a6[7:1];
        h7 = t != 7'h0 && t == a7[7:1] && !h6;
        @(posedge i_clk);
        i_txn_valid <= 1'h1;
        i_txn_addr <= t;
        i_txn_write <= w;
        @(posedge i_clk);
        i_txn_valid <= 1'h0;
        @(negedge i_clk);
        chk("fwd valid", o_fwd_valid, h6 | h7);
        chk("fwd write", o_fwd_write, w & (h6 | h7));
        chk("fwd addr", o_fwd_addr, h6 ? i_remote_id_six : (h7 ? i_remote_id_seven : 7'h0));
        chk("auto ack", o_auto_ack, w & (h6 & a6[0] | h7 & a7[0]));
        @(posedge i_clk);
    endtask : txn

    // Main sequence
    initial
    begin
        logic [7:0] v;
        logic [15:0] n;
        n = 16'h012c;
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1'h1;
        rchk("alias six", IDX_REMOTE_ALIAS_SIX, ALIAS_RESET);
        rchk("alias seven", IDX_REMOTE_ALIAS_SEVEN, ALIAS_RESET);
        rchk("control", IDX_BACK_CHANNEL_CONTROL, {5'h0, TIMER_RESET});
        rchk("revision", IDX_REVISION_AND_MASK, {REV, MASK});
        rchk("init", IDX_INIT_STATUS, 8'h0);
        rchk("general", IDX_GENERAL_LINK_STATUS, gen_exp(1'h0, 1'h0, 1'h0));
        for (int i = 0; i < 4; i++)
            rchk("count", IDX_SELFTEST_ERROR_COUNT + IDX_W'(i), 8'h0);
        $display("reset test done");
        repeat (8)
        begin
            a6 = 8'($random(seed));
            a7 = 8'($random(seed));
            i_remote_id_six <= 7'($random(seed));
            i_remote_id_seven <= 7'($random(seed));
            i_pin_levels <= 4'($random(seed));
            apb(1'h1, {IDX_REMOTE_ALIAS_SIX, 2'h0}, a6);
            apb(1'h1, {IDX_REMOTE_ALIAS_SEVEN, 2'h0}, a7);
            rchk("alias six", IDX_REMOTE_ALIAS_SIX, a6);
            rchk("alias seven", IDX_REMOTE_ALIAS_SEVEN, a7);
            rchk("pins", IDX_PIN_LEVEL_SNAPSHOT, {4'h0, i_pin_levels});
            txn(a6[7:1], 1'h1);
            txn(a7[7:1], 1'h1);
            txn(7'($random(seed)), 1'($random(seed)));
        end
        a6 = 8'h01;
        apb(1'h1, {IDX_REMOTE_ALIAS_SIX, 2'h0}, a6);
        txn(7'h0, 1'h1);
        $display("alias test done");
        for (int i = 0; i < 8; i++)
        begin
            v = {5'($random(seed)), 3'(i)};
            apb(1'h1, {IDX_BACK_CHANNEL_CONTROL, 2'h0}, v);
            rchk("control", IDX_BACK_CHANNEL_CONTROL, {5'h0, v[2:0]});
            chk("timer", o_link_detect_interval, v[2:0]);
        end
        apb(1'h0, {10'h04a, 2'h0}, 8'h0);
        chk("unmapped", err, 1'h1);
        chk("unmapped data", rd, 32'h0);
        inj_crc <= 1'h1;
        repeat (n) @(posedge i_clk);
        inj_crc <= 1'h0;
        inj_bist <= 1'h1;
        repeat (3) @(posedge i_clk);
        inj_bist <= 1'h0;
        rchk("crc low", IDX_CHECKSUM_COUNT_LOW, n[7:0]);
        rchk("crc high", IDX_CHECKSUM_COUNT_HIGH, n[15:8]);
        rchk("bist count", IDX_SELFTEST_ERROR_COUNT, 8'h03);
        rchk("general", IDX_GENERAL_LINK_STATUS, gen_exp(1'h0, 1'h1, 1'h1));
        rchk("control", IDX_BACK_CHANNEL_CONTROL, 8'h07);
        rchk("general", IDX_GENERAL_LINK_STATUS, gen_exp(1'h0, 1'h1, 1'h0));
        apb(1'h1, {IDX_BACK_CHANNEL_CONTROL, 2'h0}, 8'h27);
        rchk("bist count", IDX_SELFTEST_ERROR_COUNT, 8'h0);
        rchk("general", IDX_GENERAL_LINK_STATUS, gen_exp(1'h0, 1'h0, 1'h0));
        apb(1'h1, {IDX_BACK_CHANNEL_CONTROL, 2'h0}, 8'h0f);
        rchk("crc low", IDX_CHECKSUM_COUNT_LOW, 8'h0);
        rchk("crc high", IDX_CHECKSUM_COUNT_HIGH, 8'h0);
        link_up <= 1'h0;
        repeat (4) @(posedge i_clk);
        rchk("general", IDX_GENERAL_LINK_STATUS, gen_exp(1'h1, 1'h0, 1'h0));
        i_forward_pll_locked <= 1'h0;
        repeat (4) @(posedge i_clk);
        rchk("general", IDX_GENERAL_LINK_STATUS, gen_exp(1'h0, 1'h0, 1'h0));
        $display("status test done");
        i_init_done <= 1'h1;
        rchk("init", IDX_INIT_STATUS, 8'h40);
        i_fuse_config_valid <= 1'h1;
        rchk("init", IDX_INIT_STATUS, 8'hc0);
        for (int i = 0; i < ALARM_N; i++)
        begin
            i_limit_alarm <= ALARM_N'(1 << i);
            @(posedge i_clk);
            i_limit_alarm <= 6'h0;
            rchk("alarm", IDX_LIMIT_ALARM_FLAGS, 8'(1 << i));
            rchk("alarm", IDX_LIMIT_ALARM_FLAGS, 8'h0);
        end
        i_limit_alarm <= 6'h3f;
        rchk("alarm", IDX_LIMIT_ALARM_FLAGS, 8'h3f);
        i_limit_alarm <= 6'h0;
        rchk("alarm", IDX_LIMIT_ALARM_FLAGS, 8'h3f);
        rchk("alarm", IDX_LIMIT_ALARM_FLAGS, 8'h0);
        $display("alarm test done");
        stop_test();
    end
endmodule : testbench
